// File: rtl/cagalu_pkg.sv
package cagalu_pkg;

  localparam int unsigned REG_ADDR_W = 4;

  // register port indices
  localparam logic [3:0] IDX_B = 4'h0;
  localparam logic [3:0] IDX_L = 4'h5;
  localparam logic [3:0] IDX_A = 4'h7;
  localparam logic [3:0] IDX_FLAGS = 4'h8;
  localparam logic [3:0] IDX_SP_HI = 4'h9;
  localparam logic [3:0] IDX_SP_LO = 4'ha;
  localparam logic [3:0] IDX_STATUS = 4'hb;
  localparam logic [2:0] IDX_H = 3'h4;
  localparam logic [2:0] IDX_LO = 3'h5;
  localparam logic [2:0] IDX_ACC = 3'h7;

  // flags register layout, other bits read zero
  localparam int unsigned FB_CY = 0;
  localparam int unsigned FB_P = 2;
  localparam int unsigned FB_AC = 4;
  localparam int unsigned FB_Z = 6;
  localparam int unsigned FB_S = 7;
  localparam int unsigned STB_BUSY = 0;
  localparam int unsigned STB_BADOP = 1;

  // opcode fields
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned SRC_MSB = 2;
  localparam int unsigned DST_LSB = 3;
  localparam int unsigned DST_MSB = 5;
  localparam int unsigned RP_LSB = 4;
  localparam int unsigned RP_MSB = 5;
  localparam int unsigned GRP_LSB = 3;
  localparam int unsigned CLS_LSB = 6;
  localparam int unsigned LO4_MSB = 3;
  localparam int unsigned SIGN_BIT = 7;
  localparam int unsigned NIB_MSB = 3;
  localparam int unsigned HNIB_LSB = 4;

  localparam logic [4:0] GRP_ADD = 5'h10;
  localparam logic [4:0] GRP_ADC = 5'h11;
  localparam logic [4:0] GRP_SUB = 5'h12;
  localparam logic [4:0] GRP_SBB = 5'h13;
  localparam logic [1:0] CLS_MISC = 2'h0;
  localparam logic [2:0] LO3_INR = 3'h4;
  localparam logic [2:0] LO3_DCR = 3'h5;
  localparam logic [3:0] LO4_INX = 4'h3;
  localparam logic [3:0] LO4_DCX = 4'hb;
  localparam logic [3:0] LO4_DAD = 4'h9;
  localparam logic [7:0] OPC_ADI = 8'hc6;
  localparam logic [7:0] OPC_ACI = 8'hce;
  localparam logic [7:0] OPC_SUI = 8'hd6;
  localparam logic [7:0] OPC_SBI = 8'hde;
  localparam logic [7:0] OPC_DAA = 8'h27;
  localparam logic [2:0] SEL_MEM = 3'h6;
  localparam logic [1:0] RP_SP = 2'h3;

  // state counts, one clock per state
  localparam logic [3:0] ST_REG = 4'h4;
  localparam logic [3:0] ST_MEM = 4'h7;
  localparam logic [3:0] ST_IMM = 4'h7;
  localparam logic [3:0] ST_INC_R = 4'h5;
  localparam logic [3:0] ST_INC_M = 4'ha;
  localparam logic [3:0] ST_PAIR = 4'h5;
  localparam logic [3:0] ST_DAA = 4'h4;
  localparam logic [3:0] CNT_FLOOR = 4'h2;
  localparam logic [3:0] CNT_LAST = 4'h1;
  localparam int unsigned MAX_STATES = 15;

  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_INR, OP_DCR, OP_INX, OP_DCX, OP_DAD, OP_DAA
  } cagalu_op_e;
  typedef enum logic [1:0] {SRC_NONE, SRC_REG, SRC_MEM, SRC_IMM} cagalu_src_e;

  typedef struct packed {
    cagalu_op_e op;
    cagalu_src_e src;
    logic [3:0] states;
    logic [2:0] sel;
    logic [1:0] rp;
  } cagalu_dec_s;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] imm;
  } cagalu_instr_s;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cagalu_mem_s;
  typedef struct packed {
    logic s;
    logic z;
    logic ac;
    logic p;
    logic cy;
  } cagalu_flags_s;
  typedef struct packed {
    logic cy;
    logic ac;
    logic [7:0] res;
  } cagalu_sum_s;

  function automatic cagalu_dec_s cagalu_decode(input logic [7:0] o);
    cagalu_dec_s d;
    d = '0;
    d.op = OP_NONE;
    d.src = SRC_NONE;
    d.sel = o[SRC_MSB:SRC_LSB];
    d.rp = o[RP_MSB:RP_LSB];
    case (o[7:GRP_LSB])
      GRP_ADD: d.op = OP_ADD;
      GRP_ADC: d.op = OP_ADC;
      GRP_SUB: d.op = OP_SUB;
      GRP_SBB: d.op = OP_SBB;
      default: d.op = OP_NONE;
    endcase
    if (d.op != OP_NONE)
    begin
      d.src = (d.sel == SEL_MEM) ? SRC_MEM : SRC_REG;
      d.states = (d.sel == SEL_MEM) ? ST_MEM : ST_REG;
    end
    else if (o == OPC_ADI || o == OPC_ACI || o == OPC_SUI || o == OPC_SBI)
    begin
      d.op = (o == OPC_ADI) ? OP_ADD : (o == OPC_ACI) ? OP_ADC :
             (o == OPC_SUI) ? OP_SUB : OP_SBB;
      d.src = SRC_IMM;
      d.states = ST_IMM;
    end
    else if (o == OPC_DAA)
    begin
      d.op = OP_DAA;
      d.states = ST_DAA;
    end
    else if (o[7:CLS_LSB] == CLS_MISC)
    begin
      if (o[SRC_MSB:SRC_LSB] == LO3_INR || o[SRC_MSB:SRC_LSB] == LO3_DCR)
      begin
        d.op = (o[SRC_MSB:SRC_LSB] == LO3_INR) ? OP_INR : OP_DCR;
        d.sel = o[DST_MSB:DST_LSB];
        d.src = (d.sel == SEL_MEM) ? SRC_MEM : SRC_REG;
        d.states = (d.sel == SEL_MEM) ? ST_INC_M : ST_INC_R;
      end
      else if (o[LO4_MSB:0] == LO4_INX || o[LO4_MSB:0] == LO4_DCX)
      begin
        d.op = (o[LO4_MSB:0] == LO4_INX) ? OP_INX : OP_DCX;
        d.states = ST_PAIR;
      end
      else if (o[LO4_MSB:0] == LO4_DAD)
      begin
        d.op = OP_DAD;
      end
    end
    return d;
  endfunction : cagalu_decode

endpackage : cagalu_pkg

// File: rtl/cagalu_core.sv
// Chosen here: the address-and-strobe port and the register offsets.
module cagalu_core #(
  parameter int unsigned PAIR_ADD_STATES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue,
  input wire cagalu_pkg::cagalu_instr_s instr,
  input wire logic mem_rvalid,
  input wire logic [7:0] mem_rdata,
  output cagalu_pkg::cagalu_mem_s mem_q,
  output logic busy_q,
  output logic done_q,
  input wire logic [cagalu_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q
);

  if (PAIR_ADD_STATES < 3 || PAIR_ADD_STATES > cagalu_pkg::MAX_STATES)
  begin : g_bad_states
    $error("pair add state count must be 3..15");
  end

  typedef enum {S_IDLE, S_MEMWAIT, S_RUN} cagalu_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic srst_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      srst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      srst_n <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  cagalu_state_e state_q;
  logic [3:0] cnt_q;
  cagalu_pkg::cagalu_dec_s dec_q;
  logic [7:0] opnd_q;
  logic [7:0] rf_q [0:7];
  logic [15:0] sp_q;
  cagalu_pkg::cagalu_flags_s flags_q;
  logic bad_op_q;

  cagalu_pkg::cagalu_dec_s dec_in;
  logic take;
  logic commit;
  logic sw_wr;
  logic [7:0] acc;
  logic [15:0] hl;
  logic [15:0] pval;
  logic [15:0] pair_d;
  logic [16:0] dad_sum;
  logic byte_op;
  logic to_acc;
  cagalu_pkg::cagalu_sum_s sum;
  cagalu_pkg::cagalu_sum_s s1;
  cagalu_pkg::cagalu_flags_s fl_d;
  logic lo_fix;
  logic hi_fix;

  function automatic cagalu_pkg::cagalu_sum_s add8(input logic [7:0] a, input logic [7:0] b,
                                                   input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    cagalu_pkg::cagalu_sum_s s;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[cagalu_pkg::NIB_MSB:0]} + {1'b0, b[cagalu_pkg::NIB_MSB:0]} + {4'h0, cin};
    s.cy = full[8];
    s.ac = low[4];
    s.res = full[7:0];
    return s;
  endfunction : add8

  function automatic logic [15:0] pair_val(input logic [1:0] rp);
    logic [15:0] v;
    v = (rp == cagalu_pkg::RP_SP) ? sp_q : {rf_q[{rp, 1'b0}], rf_q[{rp, 1'b1}]};
    return v;
  endfunction : pair_val

  assign dec_in = cagalu_pkg::cagalu_decode(instr.opcode);
  assign take = (state_q == S_IDLE) && issue && (dec_in.op != cagalu_pkg::OP_NONE);
  assign commit = (state_q == S_RUN) && (cnt_q == cagalu_pkg::CNT_LAST);
  // software register, flag and SP writes land only between instructions so nothing races a commit
  assign sw_wr = reg_wr && (state_q == S_IDLE);
  assign acc = rf_q[cagalu_pkg::IDX_ACC];
  assign hl = {rf_q[cagalu_pkg::IDX_H], rf_q[cagalu_pkg::IDX_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  always_comb
  begin
    fl_d = flags_q;
    s1 = add8(acc, 8'h00, 1'b0);
    lo_fix = 1'b0;
    hi_fix = 1'b0;
    pval = pair_val(dec_q.rp);
    pair_d = (dec_q.op == cagalu_pkg::OP_INX) ? pval + 16'h0001 : pval - 16'h0001;
    dad_sum = {1'b0, hl} + {1'b0, pval};
    case (dec_q.op)
      cagalu_pkg::OP_ADD:
      begin
        sum = add8(acc, opnd_q, 1'b0);
        fl_d.cy = sum.cy;
      end
      cagalu_pkg::OP_ADC:
      begin
        sum = add8(acc, opnd_q, flags_q.cy);
        fl_d.cy = sum.cy;
      end
      cagalu_pkg::OP_SUB:
      begin
        // two's complement: A + ~b + 1, carry out inverted into borrow
        sum = add8(acc, ~opnd_q, 1'b1);
        fl_d.cy = ~sum.cy;
      end
      cagalu_pkg::OP_SBB:
      begin
        sum = add8(acc, ~opnd_q, ~flags_q.cy);
        fl_d.cy = ~sum.cy;
      end
      cagalu_pkg::OP_INR:
      begin
        sum = add8(opnd_q, 8'h00, 1'b1);
      end
      cagalu_pkg::OP_DCR:
      begin
        sum = add8(opnd_q, 8'hff, 1'b0);
      end
      cagalu_pkg::OP_DAA:
      begin
        lo_fix = (acc[cagalu_pkg::NIB_MSB:0] > cagalu_pkg::BCD_LIMIT) || flags_q.ac;
        s1 = add8(acc, lo_fix ? {4'h0, cagalu_pkg::BCD_FIX} : 8'h00, 1'b0);
        // a carry out of the first step counts as a set carry for the second
        hi_fix = (s1.res[7:cagalu_pkg::HNIB_LSB] > cagalu_pkg::BCD_LIMIT) || flags_q.cy
                 || s1.cy;
        sum = add8(s1.res, hi_fix ? {cagalu_pkg::BCD_FIX, 4'h0} : 8'h00, 1'b0);
        sum.ac = s1.ac;
        fl_d.cy = flags_q.cy | s1.cy | sum.cy;
      end
      cagalu_pkg::OP_DAD:
      begin
        sum = add8(acc, 8'h00, 1'b0);
        fl_d.cy = dad_sum[16];
      end
      default:
      begin
        sum = add8(acc, 8'h00, 1'b0);
      end
    endcase
    if (byte_op)
    begin
      fl_d.ac = sum.ac;
      fl_d.s = sum.res[cagalu_pkg::SIGN_BIT];
      fl_d.z = (sum.res == 8'h00);
      fl_d.p = ~^sum.res;
    end
  end

  assign byte_op = (dec_q.op != cagalu_pkg::OP_INX) && (dec_q.op != cagalu_pkg::OP_DCX) &&
                   (dec_q.op != cagalu_pkg::OP_DAD) && (dec_q.op != cagalu_pkg::OP_NONE);
  assign to_acc = byte_op && (dec_q.op != cagalu_pkg::OP_INR) && (dec_q.op != cagalu_pkg::OP_DCR);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: one clock per state, memory wait stretches it

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      dec_q <= '0;
      opnd_q <= 8'h00;
      mem_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      mem_q.rd <= 1'b0;
      mem_q.wr <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (take)
          begin
            dec_q <= dec_in;
            cnt_q <= (dec_in.op == cagalu_pkg::OP_DAD) ?
                     4'(PAIR_ADD_STATES - 1) : dec_in.states - 4'h1;
            opnd_q <= (dec_in.src == cagalu_pkg::SRC_IMM) ? instr.imm : rf_q[dec_in.sel];
            busy_q <= 1'b1;
            mem_q.addr <= hl;
            if (dec_in.src == cagalu_pkg::SRC_MEM)
            begin
              mem_q.rd <= 1'b1;
              state_q <= S_MEMWAIT;
            end
            else
            begin
              state_q <= S_RUN;
            end
          end
        end
        S_MEMWAIT:
        begin
          // a slow memory holds the count just short of the end
          if (cnt_q > cagalu_pkg::CNT_FLOOR || mem_rvalid)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          if (mem_rvalid)
          begin
            opnd_q <= mem_rdata;
            state_q <= S_RUN;
          end
        end
        S_RUN:
        begin
          if (commit)
          begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            if (dec_q.src == cagalu_pkg::SRC_MEM && !to_acc)
            begin
              mem_q.wr <= 1'b1;
              mem_q.wdata <= sum.res;
            end
          end
          else
          begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and flags

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        rf_q[i] <= 8'h00;
      end
      sp_q <= 16'h0000;
      flags_q <= '0;
    end
    else if (commit)
    begin
      flags_q <= fl_d;
      if (to_acc)
      begin
        rf_q[cagalu_pkg::IDX_ACC] <= sum.res;
      end
      else if (byte_op && dec_q.src == cagalu_pkg::SRC_REG)
      begin
        rf_q[dec_q.sel] <= sum.res;
      end
      else if (dec_q.op == cagalu_pkg::OP_DAD)
      begin
        rf_q[cagalu_pkg::IDX_H] <= dad_sum[15:8];
        rf_q[cagalu_pkg::IDX_LO] <= dad_sum[7:0];
      end
      else if (dec_q.op == cagalu_pkg::OP_INX || dec_q.op == cagalu_pkg::OP_DCX)
      begin
        if (dec_q.rp == cagalu_pkg::RP_SP)
        begin
          sp_q <= pair_d;
        end
        else
        begin
          rf_q[{dec_q.rp, 1'b0}] <= pair_d[15:8];
          rf_q[{dec_q.rp, 1'b1}] <= pair_d[7:0];
        end
      end
    end
    else if (sw_wr)
    begin
      if (reg_addr <= cagalu_pkg::IDX_L || reg_addr == cagalu_pkg::IDX_A)
      begin
        rf_q[reg_addr[2:0]] <= reg_wdata;
      end
      else if (reg_addr == cagalu_pkg::IDX_FLAGS)
      begin
        flags_q.s <= reg_wdata[cagalu_pkg::FB_S];
        flags_q.z <= reg_wdata[cagalu_pkg::FB_Z];
        flags_q.ac <= reg_wdata[cagalu_pkg::FB_AC];
        flags_q.p <= reg_wdata[cagalu_pkg::FB_P];
        flags_q.cy <= reg_wdata[cagalu_pkg::FB_CY];
      end
      else if (reg_addr == cagalu_pkg::IDX_SP_HI)
      begin
        sp_q[15:8] <= reg_wdata;
      end
      else if (reg_addr == cagalu_pkg::IDX_SP_LO)
      begin
        sp_q[7:0] <= reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unknown opcode flag: a new refusal wins over a clear in the same cycle

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      bad_op_q <= 1'b0;
    end
    else if ((state_q == S_IDLE) && issue && (dec_in.op == cagalu_pkg::OP_NONE))
    begin
      bad_op_q <= 1'b1;
    end
    else if (reg_wr && reg_addr == cagalu_pkg::IDX_STATUS && reg_wdata[cagalu_pkg::STB_BADOP])
    begin
      bad_op_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data valid only in the cycle after the strobe

  always_ff @(posedge clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      reg_rdata_q <= 8'h00;
    end
    else if (!reg_rd)
    begin
      reg_rdata_q <= 8'h00;
    end
    else
    begin
      reg_rdata_q <= 8'h00;
      if (reg_addr <= cagalu_pkg::IDX_L || reg_addr == cagalu_pkg::IDX_A)
      begin
        reg_rdata_q <= rf_q[reg_addr[2:0]];
      end
      else if (reg_addr == cagalu_pkg::IDX_FLAGS)
      begin
        reg_rdata_q[cagalu_pkg::FB_S] <= flags_q.s;
        reg_rdata_q[cagalu_pkg::FB_Z] <= flags_q.z;
        reg_rdata_q[cagalu_pkg::FB_AC] <= flags_q.ac;
        reg_rdata_q[cagalu_pkg::FB_P] <= flags_q.p;
        reg_rdata_q[cagalu_pkg::FB_CY] <= flags_q.cy;
      end
      else if (reg_addr == cagalu_pkg::IDX_SP_HI)
      begin
        reg_rdata_q <= sp_q[15:8];
      end
      else if (reg_addr == cagalu_pkg::IDX_SP_LO)
      begin
        reg_rdata_q <= sp_q[7:0];
      end
      else if (reg_addr == cagalu_pkg::IDX_STATUS)
      begin
        reg_rdata_q[cagalu_pkg::STB_BUSY] <= busy_q;
        reg_rdata_q[cagalu_pkg::STB_BADOP] <= bad_op_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!srst_n);

  property p_adc_reg_time;
    take && dec_in.op == cagalu_pkg::OP_ADC && dec_in.src == cagalu_pkg::SRC_REG
      |-> ##1 (!done_q)[*3] ##1 done_q;
  endproperty
  a_adc_reg_time: assert property (p_adc_reg_time) else $error("adc register not 4 states");

  property p_adc_mem_min;
    take && dec_in.op == cagalu_pkg::OP_ADC && dec_in.src == cagalu_pkg::SRC_MEM
      |-> ##1 (!done_q)[*6];
  endproperty
  a_adc_mem_min: assert property (p_adc_mem_min) else $error("adc memory ended early");

  property p_aci_time;
    take && dec_in.op == cagalu_pkg::OP_ADC && dec_in.src == cagalu_pkg::SRC_IMM
      |-> ##1 (!done_q)[*6] ##1 done_q;
  endproperty
  a_aci_time: assert property (p_aci_time) else $error("adc immediate not 7 states");

  property p_sub_reg_time;
    take && dec_in.op == cagalu_pkg::OP_SUB && dec_in.src == cagalu_pkg::SRC_REG
      |-> ##4 done_q && busy_q == 1'b0;
  endproperty
  a_sub_reg_time: assert property (p_sub_reg_time) else $error("sub register not 4 states");

  property p_sub_result;
    done_q && dec_q.op == cagalu_pkg::OP_SUB
      |-> rf_q[cagalu_pkg::IDX_ACC] == 8'($past(acc) - $past(opnd_q));
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("sub result wrong");

  property p_sub_borrow;
    done_q && dec_q.op == cagalu_pkg::OP_SUB |-> flags_q.cy == ($past(acc) < $past(opnd_q));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

  property p_inr_time;
    take && dec_in.op == cagalu_pkg::OP_INR && dec_in.src == cagalu_pkg::SRC_REG
      |-> ##1 (!done_q)[*4] ##1 done_q;
  endproperty
  a_inr_time: assert property (p_inr_time) else $error("increment register not 5 states");

  property p_incdec_cy;
    done_q && (dec_q.op == cagalu_pkg::OP_INR || dec_q.op == cagalu_pkg::OP_DCR)
      |-> flags_q.cy == $past(flags_q.cy);
  endproperty
  a_incdec_cy: assert property (p_incdec_cy) else $error("carry changed by inc or dec");

  property p_pair_flags;
    done_q && (dec_q.op == cagalu_pkg::OP_INX || dec_q.op == cagalu_pkg::OP_DCX)
      |-> flags_q == $past(flags_q);
  endproperty
  a_pair_flags: assert property (p_pair_flags) else $error("pair op changed flags");

  property p_dad_carry;
    done_q && dec_q.op == cagalu_pkg::OP_DAD
      |-> flags_q.cy == $past(dad_sum[16]) && flags_q.z == $past(flags_q.z);
  endproperty
  a_dad_carry: assert property (p_dad_carry) else $error("pair add carry wrong");

  property p_inr_mem_wb;
    done_q && dec_q.op == cagalu_pkg::OP_INR && dec_q.src == cagalu_pkg::SRC_MEM
      |-> mem_q.wr && mem_q.wdata == 8'($past(opnd_q) + 8'h01);
  endproperty
  a_inr_mem_wb: assert property (p_inr_mem_wb) else $error("memory increment write wrong");

  property p_acc_szp;
    done_q && to_acc |-> flags_q.p == ~^rf_q[cagalu_pkg::IDX_ACC] &&
      flags_q.s == rf_q[cagalu_pkg::IDX_ACC][cagalu_pkg::SIGN_BIT] &&
      flags_q.z == (rf_q[cagalu_pkg::IDX_ACC] == 8'h00);
  endproperty
  a_acc_szp: assert property (p_acc_szp) else $error("sign zero parity wrong");

  c_adc_mem: cover property (done_q && dec_q.op == cagalu_pkg::OP_ADC &&
                             dec_q.src == cagalu_pkg::SRC_MEM);
  c_daa_carry: cover property (done_q && dec_q.op == cagalu_pkg::OP_DAA && flags_q.cy);
  c_dad_carry: cover property (done_q && dec_q.op == cagalu_pkg::OP_DAD && flags_q.cy);
  c_dcr_mem: cover property (mem_q.wr && dec_q.op == cagalu_pkg::OP_DCR);

endmodule : cagalu_core

// File: test/cagalu_tb_top.sv
module cagalu_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic issue = 1'b0;
  cagalu_pkg::cagalu_instr_s instr = '0;
  logic mem_rvalid = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  cagalu_pkg::cagalu_mem_s mem_q;
  cagalu_pkg::cagalu_mem_s mq;
  logic busy_q;
  logic done_q;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q;
  logic [7:0] a, b, f, h, l, mbyte, op, v;
  logic [9:0] x;
  logic [16:0] s;
  logic [8:0] t, u;
  logic [15:0] lat, nb;
  logic [31:0] seed = 32'h0000004d;
  int mismatches = 0;
  int cmp_count = 0;
  int i, g;

  always #5 clk = ~clk;

  cagalu_core #(.PAIR_ADD_STATES(10)) DUT (.clk(clk), .rst_n(rst_n), .issue(issue),
    .instr(instr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_q(mem_q),
    .busy_q(busy_q), .done_q(done_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  // idle read data is scrambled so a stale byte can never pass for an answer
  always @(posedge clk)
  begin
    mem_rvalid <= mem_q.rd;
    mem_rdata <= mem_q.rd ? mbyte : rnd();
  end

  ////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // subtract adds the complement, so half carry is the raw bit 3 carry
  function automatic logic [9:0] ar(input logic [7:0] p, input logic [7:0] q,
    input logic c, input logic sb);
    logic [8:0] r;
    logic [4:0] n;
    q = sb ? ~q : q;
    c = sb ? ~c : c;
    r = p + q + c;
    n = p[3:0] + q[3:0] + c;
    return {r[8] ^ sb, n[4], r[7:0]};
  endfunction : ar

  function automatic logic [7:0] fl(input logic [9:0] y);
    return {y[7], y[7:0] == 8'h00, 1'b0, y[8], 1'b0, ~^y[7:0], 1'b0, y[9]};
  endfunction : fl

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rc(input logic [3:0] ad, input logic [7:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, reg_rdata_q}, {8'h00, e});
    @(posedge clk);
  endtask : rc

  task automatic run(input logic [7:0] o, input logic [7:0] im);
    lat = 16'h0000;
    nb = 16'h0000;
    instr <= {o, im};
    issue <= 1'b1;
    @(posedge clk);
    issue <= 1'b0;
    // outputs are looked at mid-cycle, where they have settled
    @(negedge clk);
    while (done_q !== 1'b1 && lat < 16'h0020)
    begin
      nb = nb + {15'h0000, busy_q};
      @(negedge clk);
      lat++;
    end
    mq = mem_q;
    chk({15'h0000, busy_q}, 16'h0000);
    // hand back on a rising edge so the next request starts there
    @(posedge clk);
  endtask : run

  task automatic summarize();
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  ////////////////////////////////////////
  initial
  begin
    #100us;
    mismatches++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rc(4'h6, 8'h00);
    h = rnd();
    l = rnd();
    wr(4'h4, h);
    wr(4'h5, l);
    for (i = 0; i < 36; i++)
    begin
      g = i % 12;
      a = rnd();
      b = rnd();
      f = rnd();
      mbyte = b;
      wr(4'h7, a);
      wr(4'h1, b);
      wr(4'h8, f);
      op = g < 4 ? {5'h10 + 5'(g), 3'h1} : g < 8 ? 8'hc6 + 8'(g * 8 - 32)
        : {5'h10 + 5'(g - 8), 3'h6};
      x = ar(a, b, g[0] & f[0], g[1]);
      run(op, b);
      chk(lat, g < 4 ? 16'h0003 : 16'h0006);
      chk(nb, g < 4 ? 16'h0003 : 16'h0006);
      rc(4'h7, x[7:0]);
      rc(4'h8, fl(x));
      if (g > 7)
        chk(mq.addr, {h, l});
    end
    // even passes use the wrap values ff and 00
    for (i = 0; i < 8; i++)
    begin
      v = i[0] ? rnd() : {8{~i[1]}};
      f = rnd();
      mbyte = v;
      wr(4'h2, v);
      wr(4'h8, f);
      x = ar(v, 8'h01, 1'b0, i[1]);
      x[9] = f[0];
      run({2'b00, i[0] ? 3'h6 : 3'h2, 2'b10, i[1]}, 8'h00);
      chk(lat, i[0] ? 16'h0009 : 16'h0004);
      if (i[0])
        chk(16'({mq.wr, mq.wdata}), 16'({1'b1, x[7:0]}));
      else
        rc(4'h2, x[7:0]);
      rc(4'h8, fl(x));
    end
    f = rnd();
    wr(4'h8, f);
    wr(4'h2, 8'hff);
    wr(4'h3, 8'hff);
    run(8'h13, 8'h00);
    chk(lat, 16'h0004);
    rc(4'h2, 8'h00);
    run(8'h1b, 8'h00);
    chk(lat, 16'h0004);
    rc(4'h3, 8'hff);
    f = f & 8'hd5;
    rc(4'h8, f);
    for (i = 0; i < 2; i++)
    begin
      b = {8{~i[0]}};
      wr(4'h0, b);
      wr(4'h1, b);
      s = {h, l} + {b, b};
      run(8'h09, 8'h00);
      chk(lat, 16'h0009);
      rc(4'h4, s[15:8]);
      rc(4'h5, s[7:0]);
      f = {f[7:1], s[16]};
      rc(4'h8, f);
      h = s[15:8];
      l = s[7:0];
    end
    for (i = 0; i < 8; i++)
    begin
      a = rnd();
      f = rnd();
      wr(4'h7, a);
      wr(4'h8, f);
      g = (a[3:0] > 4'h9 || f[4]) ? 6 : 0;
      t = a + 9'(g);
      x[8] = a[3:0] + 5'(g) > 5'h0f;
      u = t[7:0] + ((t[7:4] > 4'h9 || f[0] || t[8]) ? 9'h060 : 9'h000);
      x[9] = f[0] | t[8] | u[8];
      x[7:0] = u[7:0];
      run(8'h27, 8'h00);
      chk(lat, 16'h0003);
      rc(4'h7, x[7:0]);
      rc(4'h8, fl(x));
    end
    // an unsupported opcode never finishes and leaves the bad-opcode status bit
    run(8'h00, 8'h00);
    chk(lat, 16'h0020);
    chk(nb, 16'h0000);
    rc(4'hb, 8'h02);
    wr(4'hb, 8'h02);
    rc(4'hb, 8'h00);
    summarize();
  end
endmodule : cagalu_tb_top
